// ### logic/data_fifo.sv
// write data fifo with registered output stage
`timescale 1ns/1ns
module data_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and control
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// streams
	stream_if.snk fill,
	stream_if.src drain
);
	if (DEPTH < 2 || WIDTH < 1) $error("data_fifo needs depth >= 2 and width >= 1");

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign fill.ready = (count_reg != CW'(DEPTH));
	assign push = fill.valid & fill.ready;
	assign pop = (count_reg != '0) & (~drain.valid | drain.ready);

	always_ff @(posedge clk_in) begin
		if (clk_en_in && push) begin
			mem[wr_ptr_reg] <= fill.data;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (clk_en_in) begin
			if (push) begin
				wr_ptr_reg <= next_ptr(wr_ptr_reg);
			end
			if (pop) begin
				rd_ptr_reg <= next_ptr(rd_ptr_reg);
			end
			if (push && !pop) begin
				count_reg <= CW'(count_reg + 1'b1);
			end else if (pop && !push) begin
				count_reg <= CW'(count_reg - 1'b1);
			end
		end
	end

	// output stage holds a word until the drain side takes it
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			drain.valid <= 1'b0;
			drain.data <= '0;
		end else if (clk_en_in) begin
			if (pop) begin
				drain.valid <= 1'b1;
				drain.data <= mem[rd_ptr_reg];
			end else if (drain.ready) begin
				drain.valid <= 1'b0;
			end
		end
	end
endmodule

// ### logic/gdram_pins_pkg.sv
// shared constants and types for the graphics dram pin interface
package gdram_pins_pkg;

	////////////////////////////////////////////////////////////////////////////
	// widths
	localparam int BANKS = 4;
	localparam int BANK_W = 2;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int BYTE_W = 8;
	localparam int COL_W = 9;

	////////////////////////////////////////////////////////////////////////////
	// address field positions
	localparam int AP_BIT = 8;
	localparam int COL_LOW_W = 8;
	localparam int COL_HI_BIT = 9;

	////////////////////////////////////////////////////////////////////////////
	// command codes as {chip select, row strobe, column strobe, write enable}
	localparam logic [3:0] CODE_MRS = 4'h0;
	localparam logic [3:0] CODE_REF = 4'h1;
	localparam logic [3:0] CODE_PRE = 4'h2;
	localparam logic [3:0] CODE_ACT = 4'h3;
	localparam logic [3:0] CODE_WR = 4'h4;
	localparam logic [3:0] CODE_RD = 4'h5;
	localparam logic [3:0] CODE_NOP = 4'h7;
	localparam int CS_BIT = 3;

	////////////////////////////////////////////////////////////////////////////
	// defaults
	localparam int BURST_BEATS_DEF = 4;
	localparam int FIFO_DEPTH_DEF = 8;
	localparam int SYNC_STAGES = 3;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum {CMD_NONE, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS} cmd_t;

	typedef enum {PWR_ON, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF} power_state_t;

	typedef struct packed {
		logic ck_t;
		logic ck_c;
		logic cke;
		logic [3:0] cmd_code;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic [LANES-1:0] mask;
		logic [LANES-1:0] wstrobe;
	} pin_bundle_t;

	////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic cmd_t decode_cmd(input logic [3:0] code);
		cmd_t c;
		c = CMD_NONE;
		if (!code[CS_BIT]) begin
			case (code)
				CODE_MRS: c = CMD_MRS;
				CODE_REF: c = CMD_REF;
				CODE_PRE: c = CMD_PRE;
				CODE_ACT: c = CMD_ACT;
				CODE_WR: c = CMD_WR;
				CODE_RD: c = CMD_RD;
				CODE_NOP: c = CMD_NOP;
				default: c = CMD_NONE;
			endcase
		end
		return c;
	endfunction

	function automatic logic [COL_W-1:0] column_of(input logic [ADDR_W-1:0] a);
		return {a[COL_HI_BIT], a[COL_LOW_W-1:0]};
	endfunction

endpackage

// ### logic/graphics_dram_pin_interface.sv
// device-side command, address and data pin interface of a four-bank graphics dram
`timescale 1ns/1ns
module graphics_dram_pin_interface
	import gdram_pins_pkg::*;
#(
	parameter int BURST_BEATS = BURST_BEATS_DEF,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
	// clock and control
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// memory clock and clock enable pins
	input wire logic ck_t_in,
	input wire logic ck_c_in,
	input wire logic cke_in,
	// command and address pins
	input wire logic cs_n_in,
	input wire logic ras_n_in,
	input wire logic cas_n_in,
	input wire logic we_n_in,
	input wire logic [BANK_W-1:0] array_select_in,
	input wire logic [ADDR_W-1:0] row_col_address_in,
	// data pins
	input wire logic [DATA_W-1:0] data_lines_in,
	output logic [DATA_W-1:0] data_lines_out,
	output logic [DATA_W-1:0] data_lines_oe_out,
	input wire logic [LANES-1:0] write_byte_mask_in,
	input wire logic [LANES-1:0] write_strobe_in,
	output logic [LANES-1:0] read_strobe_out,
	output logic [LANES-1:0] read_strobe_oe_out,
	// decoded command report
	output logic cmd_valid_out,
	output cmd_t cmd_kind_out,
	output logic [BANK_W-1:0] cmd_bank_out,
	output logic [ADDR_W-1:0] row_address_out,
	output logic [COL_W-1:0] column_address_out,
	output logic auto_precharge_out,
	output logic [ADDR_W-1:0] mode_word_out,
	// device state
	output logic [BANKS-1:0] bank_open_out,
	output power_state_t power_state_out,
	output logic internal_clock_en_out,
	// write data stream
	output logic [DATA_W-1:0] wr_data_out,
	output logic [LANES-1:0] wr_byte_en_out,
	output logic wr_valid_out,
	input wire logic wr_ready_in,
	output logic write_stall_out,
	output logic write_overflow_out,
	// read data stream
	input wire logic [DATA_W-1:0] rd_data_in,
	input wire logic rd_valid_in,
	output logic rd_ready_out
);
	localparam int BEAT_W = $clog2(BURST_BEATS + 1);
	localparam int FIFO_W = DATA_W + LANES;

	if (BURST_BEATS < 1) $error("burst length must be at least one beat");
	if (FIFO_DEPTH < 2) $error("write fifo depth must be at least two");

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisation
	pin_bundle_t raw_pins;
	pin_bundle_t pins;

	assign raw_pins = {ck_t_in, ck_c_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in,
		array_select_in, row_col_address_in, data_lines_in, write_byte_mask_in,
		write_strobe_in};

	pin_sync #(.W($bits(pin_bundle_t))) u_sync (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.d_in(raw_pins),
		.q_out(pins)
	);

	////////////////////////////////////////////////////////////////////////////
	// clock crossing detection
	power_state_t state_reg;
	logic ck_phase_reg;
	logic clk_gated;
	logic ck_high;
	logic ck_low;
	logic rise_x;
	logic fall_x;
	logic cke_s;
	logic buffers_on;
	logic cmd_take;
	cmd_t cmd;

	assign cke_s = pins.cke;
	assign clk_gated = (state_reg == PWR_SELF_REF);
	assign ck_high = pins.ck_t & ~pins.ck_c;
	assign ck_low = ~pins.ck_t & pins.ck_c;
	assign rise_x = ~clk_gated & ck_high & ~ck_phase_reg;
	assign fall_x = ~clk_gated & ck_low & ck_phase_reg;
	assign buffers_on = (state_reg == PWR_ON) & cke_s;
	assign cmd = decode_cmd(pins.cmd_code);
	assign cmd_take = rise_x & buffers_on;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ck_phase_reg <= 1'b0;
		end else if (clk_en_in && !clk_gated) begin
			if (ck_high) begin
				ck_phase_reg <= 1'b1;
			end else if (ck_low) begin
				ck_phase_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power state
	logic [BANKS-1:0] bank_open_reg;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_reg <= PWR_ON;
		end else if (clk_en_in) begin
			case (state_reg)
				PWR_ON: begin
					if (rise_x && !cke_s) begin
						if (cmd == CMD_REF && bank_open_reg == '0) begin
							state_reg <= PWR_SELF_REF;
						end else if (bank_open_reg != '0) begin
							state_reg <= PWR_ACT_PD;
						end else begin
							state_reg <= PWR_PRE_PD;
						end
					end
				end
				PWR_PRE_PD, PWR_ACT_PD: begin
					if (rise_x && cke_s) begin
						state_reg <= PWR_ON;
					end
				end
				PWR_SELF_REF: begin
					if (cke_s) begin
						state_reg <= PWR_ON;
					end
				end
				default: state_reg <= PWR_ON;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			internal_clock_en_out <= 1'b0;
		end else if (clk_en_in) begin
			internal_clock_en_out <= cke_s & ~clk_gated;
		end
	end

	assign power_state_out = state_reg;
	assign bank_open_out = bank_open_reg;

	////////////////////////////////////////////////////////////////////////////
	// banks, auto-precharge and mode word
	logic [BEAT_W-1:0] rd_left_reg;
	logic [BEAT_W-1:0] wr_left_reg;
	logic ap_pending_reg;
	logic [BANK_W-1:0] ap_bank_reg;
	logic ap_close;
	logic bank_cmd;

	assign ap_close = ap_pending_reg & (rd_left_reg == '0) & (wr_left_reg == '0);
	assign bank_cmd = (cmd == CMD_RD) | (cmd == CMD_WR);

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			bank_open_reg <= '0;
			ap_pending_reg <= 1'b0;
			ap_bank_reg <= '0;
		end else if (clk_en_in) begin
			if (ap_close) begin
				bank_open_reg[ap_bank_reg] <= 1'b0;
				ap_pending_reg <= 1'b0;
			end
			if (cmd_take) begin
				if (cmd == CMD_ACT) begin
					bank_open_reg[pins.bank] <= 1'b1;
				end else if (cmd == CMD_PRE) begin
					if (pins.addr[AP_BIT]) begin
						bank_open_reg <= '0;
					end else begin
						bank_open_reg[pins.bank] <= 1'b0;
					end
				end else if (bank_cmd && pins.addr[AP_BIT]) begin
					ap_pending_reg <= 1'b1;
					ap_bank_reg <= pins.bank;
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cmd_valid_out <= 1'b0;
			cmd_kind_out <= CMD_NONE;
			cmd_bank_out <= '0;
			row_address_out <= '0;
			column_address_out <= '0;
			auto_precharge_out <= 1'b0;
			mode_word_out <= '0;
		end else if (clk_en_in) begin
			cmd_valid_out <= cmd_take && cmd != CMD_NONE;
			if (cmd_take && cmd != CMD_NONE) begin
				cmd_kind_out <= cmd;
				cmd_bank_out <= pins.bank;
				if (cmd == CMD_ACT) begin
					row_address_out <= pins.addr;
				end
				if (bank_cmd) begin
					column_address_out <= column_of(pins.addr);
				end
				auto_precharge_out <= bank_cmd & pins.addr[AP_BIT];
				if (cmd == CMD_MRS) begin
					mode_word_out <= pins.addr;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read burst
	logic rd_take;
	logic rd_drive_reg;
	logic rd_strobe_reg;

	assign rd_take = rd_ready_out & rd_valid_in;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rd_left_reg <= '0;
			rd_ready_out <= 1'b0;
			rd_drive_reg <= 1'b0;
			rd_strobe_reg <= 1'b0;
			data_lines_out <= '0;
		end else if (clk_en_in) begin
			rd_ready_out <= (rd_left_reg != '0) & (rise_x | fall_x) & cke_s & ~rd_take;
			if (cmd_take && cmd == CMD_RD) begin
				rd_left_reg <= BEAT_W'(BURST_BEATS);
			end else if (rd_take && rd_left_reg != '0) begin
				rd_left_reg <= BEAT_W'(rd_left_reg - 1'b1);
			end
			if (rd_take) begin
				data_lines_out <= rd_data_in;
				rd_strobe_reg <= ~rd_strobe_reg;
				rd_drive_reg <= 1'b1;
			end else if (!cke_s || (rd_left_reg == '0 && (rise_x || fall_x))) begin
				rd_drive_reg <= 1'b0;
			end
		end
	end

	assign data_lines_oe_out = {DATA_W{rd_drive_reg}};
	assign read_strobe_out = {LANES{rd_strobe_reg}};
	assign read_strobe_oe_out = {LANES{rd_drive_reg}};

	////////////////////////////////////////////////////////////////////////////
	// write burst into the fifo
	stream_if #(.W(FIFO_W)) fill_if ();
	stream_if #(.W(FIFO_W)) drain_if ();
	logic [LANES-1:0] ws_prev_reg;
	logic wr_beat;
	logic wr_store;
	logic push_valid_reg;
	logic [FIFO_W-1:0] push_data_reg;

	assign wr_beat = (|(pins.wstrobe ^ ws_prev_reg)) & (wr_left_reg != '0) & buffers_on;
	assign wr_store = wr_beat & ~(&pins.mask);
	assign fill_if.valid = push_valid_reg;
	assign fill_if.data = push_data_reg;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ws_prev_reg <= '0;
			wr_left_reg <= '0;
		end else if (clk_en_in) begin
			ws_prev_reg <= pins.wstrobe;
			if (cmd_take && cmd == CMD_WR) begin
				wr_left_reg <= BEAT_W'(BURST_BEATS);
			end else if (wr_beat) begin
				wr_left_reg <= BEAT_W'(wr_left_reg - 1'b1);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			push_valid_reg <= 1'b0;
			push_data_reg <= '0;
			write_overflow_out <= 1'b0;
			write_stall_out <= 1'b0;
		end else if (clk_en_in) begin
			write_stall_out <= ~fill_if.ready;
			if (wr_store) begin
				push_valid_reg <= 1'b1;
				push_data_reg <= {~pins.mask, pins.dq};
				if (push_valid_reg && !fill_if.ready) begin
					write_overflow_out <= 1'b1;
				end
			end else if (fill_if.ready) begin
				push_valid_reg <= 1'b0;
			end
		end
	end

	data_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.fill(fill_if.snk),
		.drain(drain_if.src)
	);

	assign drain_if.ready = wr_ready_in;
	assign wr_valid_out = drain_if.valid;
	assign wr_data_out = drain_if.data[DATA_W-1:0];
	assign wr_byte_en_out = drain_if.data[FIFO_W-1:DATA_W];
endmodule

// ### logic/pin_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 1
) (
	// clock and control
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// data
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	if (W < 1) $error("pin_sync width must be positive");

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else if (clk_en_in) begin
			s1_reg <= d_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// a bit changes only once stages two and three agree
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			q_out <= '0;
		end else if (clk_en_in) begin
			q_out <= (~(s2_reg ^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & q_out);
		end
	end
endmodule

// ### logic/stream_if.sv
// valid/ready stream carrier between the block's own modules
`timescale 1ns/1ns
interface stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// ### sim/gdram_ctrl_model.sv
// behavioural memory controller driving the dram pins
`timescale 1ns/1ns
module gdram_ctrl_model
	import gdram_pins_pkg::*;
(
	// system clock
	input wire logic clk_in,
	// pins toward the device
	output logic ck_t_out,
	output logic ck_c_out,
	output logic cke_out,
	output logic [3:0] code_out,
	output logic [BANK_W-1:0] bank_out,
	output logic [ADDR_W-1:0] addr_out,
	output logic [DATA_W-1:0] dq_out,
	output logic [LANES-1:0] mask_out,
	output logic [LANES-1:0] wstrobe_out
);
	logic run = 1'b1;
	int cnt = 0;
	initial begin
		ck_t_out = 1'b0;
		cke_out = 1'b0;
		code_out = 4'hF;
		bank_out = 2'h0;
		addr_out = 12'h000;
		dq_out = 32'h0;
		mask_out = 4'h0;
		wstrobe_out = 4'h0;
	end
	assign ck_c_out = ~ck_t_out;
	// memory clock runs free unless self refresh stops it
	always @(posedge clk_in) begin
		cnt <= (cnt == 7) ? 0 : cnt + 1;
		if (run && cnt == 7)
			ck_t_out <= #1 ~ck_t_out;
	end
	// command set up at a fall, held past the rise, then deselected
	task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic e);
		@(negedge ck_t_out);
		@(posedge clk_in);
		#1 code_out = c;
		bank_out = b;
		addr_out = a;
		cke_out = e;
		@(posedge ck_t_out);
		repeat (7) @(posedge clk_in);
		#1 code_out = 4'hF;
		addr_out = ~a;
	endtask
	// one beat, strobe toggled mid-eye, data released after
	task automatic wbeat(input logic [31:0] d, input logic [3:0] m);
		dq_out = d;
		mask_out = m;
		repeat (4) @(posedge clk_in);
		#1 wstrobe_out = ~wstrobe_out;
		repeat (3) @(posedge clk_in);
		#1 dq_out = ~d;
		@(posedge clk_in);
		#1;
	endtask
endmodule

// ### sim/gdram_pins_assertions.sv
// port-level assertions for the graphics dram pin interface
`timescale 1ns/1ns
module gdram_pins_assertions
	import gdram_pins_pkg::*;
(
	// clock, reset and user inputs
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic rd_valid_in,
	input wire logic [DATA_W-1:0] rd_data_in,
	input wire logic wr_ready_in,
	// watched outputs
	input wire logic [DATA_W-1:0] data_lines_out,
	input wire logic [DATA_W-1:0] data_lines_oe_out,
	input wire logic [LANES-1:0] read_strobe_out,
	input wire logic [LANES-1:0] read_strobe_oe_out,
	input wire logic cmd_valid_out,
	input cmd_t cmd_kind_out,
	input wire logic [BANK_W-1:0] cmd_bank_out,
	input wire logic [ADDR_W-1:0] row_address_out,
	input wire logic [COL_W-1:0] column_address_out,
	input wire logic [ADDR_W-1:0] mode_word_out,
	input wire logic [BANKS-1:0] bank_open_out,
	input power_state_t power_state_out,
	input wire logic internal_clock_en_out,
	input wire logic [DATA_W-1:0] wr_data_out,
	input wire logic [LANES-1:0] wr_byte_en_out,
	input wire logic wr_valid_out,
	input wire logic rd_ready_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	sequence rd_take;
		rd_ready_out && rd_valid_in;
	endsequence
	sequence rd_shown;
		read_strobe_out == ~$past(read_strobe_out) && data_lines_out == $past(rd_data_in);
	endsequence
	a_read_word_out: assert property (rd_take |=> rd_shown)
		else $error("read word not shown with a strobe toggle");
	a_oe_after_take: assert property ($rose(data_lines_oe_out[0]) |->
		$past(rd_ready_out && rd_valid_in) && (&read_strobe_oe_out))
		else $error("data lines driven without a taken read word");
	a_cmd_pulse_single: assert property (cmd_valid_out |=> !cmd_valid_out [*6])
		else $error("more than one command per crossing");
	a_row_on_act: assert property ($changed(row_address_out) |-> cmd_kind_out == CMD_ACT)
		else $error("row changed outside activate");
	a_col_on_rdwr: assert property ($changed(column_address_out) |->
		cmd_valid_out && cmd_kind_out inside {CMD_RD, CMD_WR})
		else $error("column changed outside read or write");
	a_mode_on_mrs: assert property ($changed(mode_word_out) |-> cmd_kind_out == CMD_MRS)
		else $error("mode word changed outside mode set");
	a_act_opens_bank: assert property (cmd_valid_out && cmd_kind_out == CMD_ACT |->
		bank_open_out[cmd_bank_out])
		else $error("activate left its bank closed");
	a_no_cmd_asleep: assert property (
		power_state_out != PWR_ON && $past(power_state_out) != PWR_ON |-> !cmd_valid_out)
		else $error("command reported while powered down");
	a_self_ref_gated: assert property (power_state_out == PWR_SELF_REF |->
		!internal_clock_en_out)
		else $error("internal clock on in self refresh");
	a_wr_word_holds: assert property (wr_valid_out && !wr_ready_in |=>
		wr_valid_out && $stable(wr_data_out))
		else $error("write word dropped while stalled");
	a_masked_not_stored: assert property (wr_valid_out |-> wr_byte_en_out != 4'h0)
		else $error("fully masked beat was stored");
endmodule

// ### sim/graphics_dram_pin_interface_bench.sv
// self-checking bench for the graphics dram pin interface
`timescale 1ns/1ns
module graphics_dram_pin_interface_bench;
	import gdram_pins_pkg::*;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic ck_t_in, ck_c_in, cke_in, cmd_valid_out, auto_precharge_out, internal_clock_en_out;
	logic [3:0] code;
	logic [BANK_W-1:0] array_select_in, cmd_bank_out;
	logic [ADDR_W-1:0] row_col_address_in, row_address_out, mode_word_out;
	logic [DATA_W-1:0] data_lines_in, data_lines_out, data_lines_oe_out, dq_drv, wr_data_out;
	logic [DATA_W-1:0] rd_data_in = 32'h0;
	logic [LANES-1:0] write_byte_mask_in, write_strobe_in, read_strobe_out, wr_byte_en_out;
	logic [LANES-1:0] read_strobe_oe_out, last_strobe = 4'h0;
	logic wr_valid_out, write_stall_out, write_overflow_out, rd_ready_out;
	logic wr_ready_in = 1'b0, rd_valid_in = 1'b0, clk_en = 1'b1;
	logic [COL_W-1:0] column_address_out;
	logic [BANKS-1:0] bank_open_out;
	cmd_t cmd_kind_out;
	power_state_t power_state_out;
	int fails = 0, checks_done = 0, seed = 32'h0B2E6460, cycles = 0, pulses = 0;
	int rd_skips = 0, shown = 0, ready_mode = 1;
	logic [35:0] wexp[$], wgot[$];
	logic [31:0] rd_q[$];
	initial forever #5 clk_in = ~clk_in;
	assign data_lines_in = data_lines_oe_out[0] ? data_lines_out : dq_drv;
	gdram_ctrl_model ctl (.clk_in, .ck_t_out(ck_t_in), .ck_c_out(ck_c_in), .cke_out(cke_in),
		.code_out(code), .bank_out(array_select_in), .addr_out(row_col_address_in),
		.dq_out(dq_drv), .mask_out(write_byte_mask_in), .wstrobe_out(write_strobe_in));
	graphics_dram_pin_interface #(.BURST_BEATS(4), .FIFO_DEPTH(8)) DUT (.clk_in, .sys_rst_in,
		.clk_en_in(clk_en), .ck_t_in, .ck_c_in, .cke_in, .cs_n_in(code[3]), .ras_n_in(code[2]),
		.cas_n_in(code[1]), .we_n_in(code[0]), .array_select_in, .row_col_address_in,
		.data_lines_in, .data_lines_out, .data_lines_oe_out, .write_byte_mask_in,
		.write_strobe_in, .read_strobe_out, .read_strobe_oe_out, .cmd_valid_out, .cmd_kind_out,
		.cmd_bank_out, .row_address_out, .column_address_out, .auto_precharge_out,
		.mode_word_out, .bank_open_out, .power_state_out, .internal_clock_en_out, .wr_data_out,
		.wr_byte_en_out, .wr_valid_out, .wr_ready_in, .write_stall_out, .write_overflow_out,
		.rd_data_in, .rd_valid_in, .rd_ready_out);
	function automatic logic [31:0] lanes(input logic [3:0] be);
		for (int i = 0; i < LANES; i++)
			lanes[i*8 +: 8] = {8{be[i]}};
	endfunction
	task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////////////
	// monitors, user-side read source, stalling write sink, timeout
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cmd_valid_out === 1'b1)
			pulses <= pulses + 1;
		if (wr_valid_out === 1'b1 && wr_ready_in)
			wgot.push_back({wr_byte_en_out, wr_data_out & lanes(wr_byte_en_out)});
		if (rd_ready_out === 1'b1 && rd_valid_in) begin
			rd_q.push_back(rd_data_in);
			rd_data_in <= #1 $random(seed);
		end
		if (rd_ready_out === 1'b1 && !rd_valid_in) begin
			rd_skips <= rd_skips + 1;
			rd_valid_in <= #1 1'b1;
		end
		if (sys_rst_in)
			last_strobe <= 4'h0;
		else if (read_strobe_out !== last_strobe) begin
			chk("read word", rd_q.pop_front(), data_lines_out);
			shown <= shown + 1;
			last_strobe <= read_strobe_out;
		end
		wr_ready_in <= #1 (ready_mode == 2) ? 1'($random(seed)) : ready_mode[0];
		if (cycles == 30000) begin
			fails++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////////////////////
	// write burst with one optional fully masked beat
	task automatic burst(input logic [1:0] b, input logic ap, input logic hole);
		logic [11:0] a;
		logic [31:0] d;
		logic [3:0] m;
		a = 12'($random(seed));
		a[AP_BIT] = ap;
		ctl.cmd(CODE_ACT, b, a, 1'b1);
		ctl.cmd(CODE_WR, b, a, 1'b1);
		chk("column", {a[COL_HI_BIT], a[COL_LOW_W-1:0]}, column_address_out);
		chk("auto precharge", ap, auto_precharge_out);
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			m = (hole && i == 2) ? 4'hF : 4'($random(seed)) % 4'hF;
			if (m != 4'hF)
				wexp.push_back({~m, d & lanes(~m)});
			ctl.wbeat(d, m);
		end
		repeat (12) @(posedge clk_in);
		#1 chk("bank after burst", !ap, bank_open_out[b]);
	endtask
	task automatic cmp_writes(input int n);
		chk("write count", 1, wgot.size() >= n);
		for (int i = 0; i < n && wgot.size() > 0; i++)
			chk("write word", wexp.pop_front(), wgot.pop_front());
		wexp.delete();
		wgot.delete();
	endtask
	////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [11:0] a;
		logic [1:0] b;
		int p;
		repeat (10) @(posedge clk_in);
		#1 sys_rst_in = 1'b0;
		a = 12'($random(seed));
		b = 2'($random(seed));
		ctl.cmd(CODE_NOP, 2'h0, 12'h000, 1'b1);
		ctl.cmd(CODE_NOP, 2'h0, 12'h000, 1'b1);
		chk("nop", CMD_NOP, cmd_kind_out);
		ctl.cmd(CODE_MRS, 2'h0, a, 1'b1);
		chk("mode word", a, mode_word_out);
		ctl.cmd(CODE_REF, 2'h0, 12'h000, 1'b1);
		chk("refresh", CMD_REF, cmd_kind_out);
		ctl.cmd(CODE_ACT, b, a, 1'b1);
		chk("row", a, row_address_out);
		chk("bank", b, cmd_bank_out);
		p = pulses;
		ctl.cmd(CODE_PRE | 4'h8, b, 12'h100, 1'b1);
		chk("deselect pulses", p, pulses);
		chk("deselect banks", 4'h1 << b, bank_open_out);
		ctl.cmd(CODE_ACT, b ^ 2'h1, a, 1'b1);
		ctl.cmd(CODE_PRE, b ^ 2'h1, 12'h000, 1'b1);
		chk("precharge one", 4'h1 << b, bank_open_out);
		ctl.cmd(CODE_PRE, b ^ 2'h2, 12'h100, 1'b1);
		chk("precharge all", 4'h0, bank_open_out);
		$display("test decode finished");
		ready_mode = 2;
		burst(b, 1'b1, 1'b1);
		burst(b ^ 2'h3, 1'b0, 1'b0);
		repeat (30) @(posedge clk_in);
		#1 cmp_writes(7);
		$display("test write finished");
		rd_valid_in = 1'b0;
		ctl.cmd(CODE_RD, b ^ 2'h3, 12'h0FF, 1'b1);
		repeat (70) @(posedge clk_in);
		#1 chk("read skips", 1, rd_skips);
		chk("read words", 4, shown);
		chk("read oe off", 32'h0, data_lines_oe_out);
		$display("test read finished");
		ready_mode = 0;
		repeat (3)
			burst(b, 1'b0, 1'b0);
		chk("stall", 1'b1, write_stall_out);
		chk("overflow", 1'b1, write_overflow_out);
		ready_mode = 1;
		repeat (40) @(posedge clk_in);
		#1 cmp_writes(8);
		chk("drained", 1'b0, wr_valid_out);
		$display("test fill finished");
		ctl.cmd(CODE_NOP, 2'h0, 12'h000, 1'b0);
		chk("active pd", PWR_ACT_PD, power_state_out);
		p = pulses;
		ctl.cmd(CODE_MRS, 2'h0, ~a, 1'b0);
		chk("pd ignores", p, pulses);
		ctl.cmd(CODE_NOP, 2'h0, 12'h000, 1'b1);
		chk("pd exit", PWR_ON, power_state_out);
		ctl.cmd(CODE_PRE, 2'h0, 12'h100, 1'b1);
		ctl.cmd(CODE_NOP, 2'h0, 12'h000, 1'b0);
		chk("precharge pd", PWR_PRE_PD, power_state_out);
		ctl.cmd(CODE_NOP, 2'h0, 12'h000, 1'b1);
		ctl.cmd(CODE_REF, 2'h0, 12'h000, 1'b0);
		chk("self refresh", PWR_SELF_REF, power_state_out);
		chk("clocks off", 1'b0, internal_clock_en_out);
		ctl.run = 1'b0;
		repeat (20) @(posedge clk_in);
		#1 ctl.cke_out = 1'b1;
		repeat (8) @(posedge clk_in);
		#1 chk("sr exit", PWR_ON, power_state_out);
		chk("clocks on", 1'b1, internal_clock_en_out);
		ctl.run = 1'b1;
		$display("test power finished");
		p = pulses;
		clk_en = 1'b0;
		ctl.cmd(CODE_MRS, 2'h0, ~a, 1'b1);
		clk_en = 1'b1;
		chk("frozen pulses", p, pulses);
		chk("frozen mode", a, mode_word_out);
		$display("test freeze finished");
		chk("overflow sticky", 1'b1, write_overflow_out);
		sys_rst_in = 1'b1;
		repeat (4) @(posedge clk_in);
		#1 sys_rst_in = 1'b0;
		@(posedge clk_in);
		#1 chk("overflow cleared", 1'b0, write_overflow_out);
		chk("kind cleared", CMD_NONE, cmd_kind_out);
		$display("test reset finished");
		conclude();
	end
endmodule
bind graphics_dram_pin_interface gdram_pins_assertions chk_i (.clk_in, .sys_rst_in, .rd_valid_in,
	.rd_data_in, .wr_ready_in, .data_lines_out, .data_lines_oe_out, .read_strobe_out,
	.read_strobe_oe_out, .cmd_valid_out, .cmd_kind_out, .cmd_bank_out, .row_address_out,
	.column_address_out, .mode_word_out, .bank_open_out, .power_state_out,
	.internal_clock_en_out, .wr_data_out, .wr_byte_en_out, .wr_valid_out, .rd_ready_out);
